//--- rtl/aik_consts.svh
// constants for the two-wire bus controller: timing, addresses, codes
`ifndef AIK_CONSTS_SVH
`define AIK_CONSTS_SVH
// ----------------------------------------
// clock and bus timing
// ----------------------------------------
`define AIK_CLK_HZ 10000000
`define AIK_SCL_HZ 100000
// quarter period of the bus clock in system cycles, rounded down
`define AIK_QTR_CYC ((`AIK_CLK_HZ / `AIK_SCL_HZ) / 4)
// idle limit of the device in ms; the controller never idles mid-frame
`define AIK_TIMEOUT_MS 25
// ----------------------------------------
// addresses and codes
// ----------------------------------------
`define AIK_ADDR_BASE 7'h48
`define AIK_ADDR_GCALL 7'h00
`define AIK_GCALL_RESET 8'h06
`define AIK_HS_CODE 8'h08
// ----------------------------------------
// fifo
// ----------------------------------------
`define AIK_FIFO_DEPTH 8
`define AIK_FIFO_AW 3
`endif

//--- rtl/aik_ctrl.sv
// two-wire bus controller that drives a small converter target
// What this block does
// - lines only pulled low or released
// - eight-bit bytes, data changes while clock low
// - start: data falls while clock high
// - stop: data rises while clock high
// - address byte: seven bits plus direction
// - controller acknowledges each byte read except the last
// - repeated start opens new address phase
// - high-speed code 00001xxx after start
// - write: pointer byte then two data bytes
// - sixteen-bit values cross upper byte first
// - read ends by not-acknowledge or stop
module aik_ctrl
   import aik_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire aik_cmd_type cmd,
   output logic rsp_valid,
   output aik_rsp_type rsp,
   output logic busy,
   output logic scl_o,
   output logic scl_oe,
   input wire logic scl_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic sda_i
);
`include "aik_consts.svh"
   // ----------------------------------------
   // command queue
   // ----------------------------------------
   aik_cmd_type q_data;
   logic q_valid;
   logic q_ready;
   aik_fifo #(.WIDTH($bits(aik_cmd_type)), .DEPTH(`AIK_FIFO_DEPTH), .AW(`AIK_FIFO_AW)) u_fifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .in_valid(cmd_valid),
      .in_ready(cmd_ready),
      .in_data(cmd),
      .out_valid(q_valid),
      .out_ready(q_ready),
      .out_data(q_data)
   );
   // ----------------------------------------
   // pin input synchronisers
   // ----------------------------------------
   logic [2:0] sda_sync_reg;  // three stages, last two agree
   logic [2:0] scl_sync_reg;
   logic sda_reg;             // filtered data line
   logic scl_reg;             // filtered clock line
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         sda_sync_reg <= 3'h7;
         scl_sync_reg <= 3'h7;
         sda_reg <= 1'b1;
         scl_reg <= 1'b1;
      end
      else
      begin
         sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
         scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
         // a change counts once stages two and three agree
         if (sda_sync_reg[1] == sda_sync_reg[2])
         begin
            sda_reg <= sda_sync_reg[2];
         end
         if (scl_sync_reg[1] == scl_sync_reg[2])
         begin
            scl_reg <= scl_sync_reg[2];
         end
      end
   end
   // ----------------------------------------
   // quarter-bit tick divider
   // ----------------------------------------
   logic [7:0] div_reg;
   logic tick;
   logic stretch;  // target holds clock low
   assign tick = (div_reg == 8'(`AIK_QTR_CYC - 1)) && !stretch;
   always_ff @(posedge clk_sys)
   begin
      if (rst || tick)
      begin
         div_reg <= 8'h00;
      end
      else if (!stretch)
      begin
         div_reg <= div_reg + 8'h01;
      end
   end
   // ----------------------------------------
   // byte sequencer
   // ----------------------------------------
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_BIT = 3'b011,
      ST_STOP = 3'b010,
      ST_DONE = 3'b110
   } aik_state_type;
   aik_state_type state_reg;
   aik_cmd_type cur_reg;       // command in flight
   logic [1:0] phase_reg;      // quarter within a bit
   logic [3:0] bit_reg;        // 0..7 data, 8 acknowledge
   logic [2:0] byte_reg;       // byte index in the frame
   logic [7:0] tx_reg;         // byte being sent
   logic [15:0] rx_reg;        // read bytes, upper first
   logic nack_reg;
   logic rsp_valid_reg;
   logic scl_low_reg;          // we pull clock low
   logic sda_low_reg;          // we pull data low
   logic is_read;
   logic last_byte;
   logic [7:0] next_tx;
   // target address from its select strap
   function automatic logic [6:0] aik_target(input logic [1:0] s);
      aik_target = `AIK_ADDR_BASE | {5'h00, s};
   endfunction : aik_target
   assign is_read = cur_reg.op == AIK_OP_READ;
   // clock held low by the target at the end of the high quarter; sampling waits for it
   assign stretch = (state_reg == ST_BIT) && !scl_low_reg && !scl_reg && phase_reg == 2'h2
      && div_reg == 8'(`AIK_QTR_CYC - 1);
   // byte count per frame, address byte included
   always_comb
   begin
      case (cur_reg.op)
         AIK_OP_WRITE: last_byte = byte_reg == 3'h3;
         AIK_OP_HS: last_byte = byte_reg == 3'h4;
         AIK_OP_READ: last_byte = byte_reg == 3'h2;
         default: last_byte = byte_reg == 3'h1;
      endcase
   end
   // byte to send after the current one
   always_comb
   begin
      case (cur_reg.op)
         AIK_OP_HS:
            case (byte_reg)
               3'h0: next_tx = {aik_target(cur_reg.sel), 1'b0};
               3'h1: next_tx = {6'h00, cur_reg.ptr};
               3'h2: next_tx = cur_reg.data[15:8];
               default: next_tx = cur_reg.data[7:0];
            endcase
         AIK_OP_GRESET: next_tx = `AIK_GCALL_RESET;
         default:
            case (byte_reg)
               3'h0: next_tx = {6'h00, cur_reg.ptr};
               3'h1: next_tx = cur_reg.data[15:8];
               default: next_tx = cur_reg.data[7:0];
            endcase
      endcase
   end
   // first byte of a frame
   function automatic logic [7:0] aik_first(input aik_cmd_type c);
      case (c.op)
         AIK_OP_GRESET: aik_first = {`AIK_ADDR_GCALL, 1'b0};
         AIK_OP_HS: aik_first = `AIK_HS_CODE;
         AIK_OP_READ: aik_first = {aik_target(c.sel), 1'b1};
         default: aik_first = {aik_target(c.sel), 1'b0};
      endcase
   endfunction : aik_first
   assign q_ready = (state_reg == ST_IDLE);
   // frame sequencing; start, bit and stop steps run on quarter ticks
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state_reg <= ST_IDLE;
         cur_reg <= '0;
         phase_reg <= 2'h0;
         bit_reg <= 4'h0;
         byte_reg <= 3'h0;
         tx_reg <= 8'h00;
         rx_reg <= 16'h0000;
         nack_reg <= 1'b0;
         scl_low_reg <= 1'b0;
         sda_low_reg <= 1'b0;
         rsp_valid_reg <= 1'b0;
      end
      else
      begin
         rsp_valid_reg <= 1'b0;
         case (state_reg)
            ST_IDLE:
            begin
               if (q_valid)
               begin
                  cur_reg <= q_data;
                  tx_reg <= aik_first(q_data);
                  byte_reg <= 3'h0;
                  bit_reg <= 4'h0;
                  phase_reg <= 2'h0;
                  nack_reg <= 1'b0;
                  state_reg <= ST_START;
               end
            end
            ST_START:
            begin
               if (tick)
               begin
                  phase_reg <= phase_reg + 2'h1;
                  // quarter 0: let the clock up, which turns this into a repeated start mid-frame
                  if (phase_reg == 2'h0)
                  begin
                     scl_low_reg <= 1'b0;
                  end
                  // quarter 1: data low under high clock, quarter 3: clock low
                  if (phase_reg == 2'h1)
                  begin
                     sda_low_reg <= 1'b1;
                  end
                  if (phase_reg == 2'h3)
                  begin
                     scl_low_reg <= 1'b1;
                     state_reg <= ST_BIT;
                  end
               end
            end
            ST_BIT:
            begin
               if (tick)
               begin
                  phase_reg <= phase_reg + 2'h1;
                  case (phase_reg)
                     2'h0:
                     begin
                        // set data while clock low
                        if (bit_reg == 4'h8)
                        begin
                           // acknowledge slot: we pull only when reading more
                           sda_low_reg <= is_read && byte_reg != 3'h0 && !last_byte;
                        end
                        else if (is_read && byte_reg != 3'h0)
                        begin
                           sda_low_reg <= 1'b0;  // target drives, we release
                        end
                        else
                        begin
                           sda_low_reg <= !tx_reg[3'h7 - bit_reg[2:0]];
                        end
                     end
                     2'h1: scl_low_reg <= 1'b0;  // release, pullup raises it
                     2'h2:
                     begin
                        // sample on clock high
                        if (bit_reg == 4'h8)
                        begin
                           if (!(is_read && byte_reg != 3'h0) && sda_reg)
                           begin
                              // hs code is expected to go unanswered
                              nack_reg <= nack_reg || !(cur_reg.op == AIK_OP_HS && byte_reg == 3'h0);
                           end
                        end
                        else if (is_read && byte_reg != 3'h0)
                        begin
                           rx_reg <= {rx_reg[14:0], sda_reg};
                        end
                     end
                     default:
                     begin
                        scl_low_reg <= 1'b1;
                        if (bit_reg == 4'h8)
                        begin
                           bit_reg <= 4'h0;
                           byte_reg <= byte_reg + 3'h1;
                           tx_reg <= next_tx;
                           if (last_byte)
                           begin
                              state_reg <= ST_STOP;
                           end
                           else if (cur_reg.op == AIK_OP_HS && byte_reg == 3'h0)
                           begin
                              state_reg <= ST_START;  // repeated start before the address
                           end
                        end
                        else
                        begin
                           bit_reg <= bit_reg + 4'h1;
                        end
                     end
                  endcase
               end
            end
            ST_STOP:
            begin
               if (tick)
               begin
                  phase_reg <= phase_reg + 2'h1;
                  case (phase_reg)
                     2'h0: sda_low_reg <= 1'b1;
                     2'h1: scl_low_reg <= 1'b0;
                     2'h2: sda_low_reg <= 1'b0;
                     default: state_reg <= ST_DONE;
                  endcase
               end
            end
            ST_DONE:
            begin
               rsp_valid_reg <= 1'b1;
               state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
   // ----------------------------------------
   // registered outputs; lines only pulled low
   // ----------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         busy <= 1'b0;
      end
      else
      begin
         scl_oe <= scl_low_reg;
         sda_oe <= sda_low_reg;
         busy <= state_reg != ST_IDLE;
      end
   end
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign rsp_valid = rsp_valid_reg;
   assign rsp = '{data: rx_reg, nack: nack_reg};
endmodule : aik_ctrl

//--- rtl/aik_fifo.sv
// small synchronous fifo with valid and ready on both sides
module aik_fifo #(
   parameter int WIDTH = 25,
   parameter int DEPTH = 8,
   parameter int AW = 3
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   // ----------------------------------------
   // storage and pointers
   // ----------------------------------------
   logic [WIDTH-1:0] mem_reg [DEPTH];  // word store
   logic [AW:0] wr_reg;                // write pointer with wrap bit
   logic [AW:0] rd_reg;                // read pointer with wrap bit
   logic push;
   logic pop;
   // full when pointers differ only in the wrap bit
   assign in_ready = (wr_reg ^ rd_reg) != {1'b1, {AW{1'b0}}};
   assign out_valid = wr_reg != rd_reg;
   assign out_data = mem_reg[rd_reg[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   // store incoming word
   always_ff @(posedge clk_sys)
   begin
      if (push)
      begin
         mem_reg[wr_reg[AW-1:0]] <= in_data;
      end
   end
   // pointer update
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         wr_reg <= '0;
         rd_reg <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_reg <= rd_reg + 1'b1;
         end
      end
   end
endmodule : aik_fifo

//--- rtl/aik_pkg.sv
// types shared by the two-wire bus controller files
package aik_pkg;
   // ----------------------------------------
   // command kinds
   // ----------------------------------------
   typedef enum logic [2:0]
   {
      AIK_OP_WRITE = 3'h0,  // pointer then two data bytes
      AIK_OP_PTR = 3'h1,    // pointer only
      AIK_OP_READ = 3'h2,   // two bytes from stored pointer
      AIK_OP_GRESET = 3'h3, // general call reset
      AIK_OP_HS = 3'h4      // high-speed code, then write
   } aik_op_type;
   // one queued command
   typedef struct packed
   {
      aik_op_type op;
      logic [1:0] sel;   // address select pin strap of the target
      logic [1:0] ptr;   // register pointer
      logic [15:0] data; // write value, upper byte first on the bus
   } aik_cmd_type;
   // one finished command
   typedef struct packed
   {
      logic [15:0] data; // read value
      logic nack;        // some byte not acknowledged
   } aik_rsp_type;
endpackage : aik_pkg

//--- verification/aik_ctrl_asserts.sv
// port-level assertions on the two-wire bus controller
module aik_ctrl_asserts
   import aik_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire aik_cmd_type cmd,
   input wire logic rsp_valid,
   input wire aik_rsp_type rsp,
   input wire logic busy,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic sda_i
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // helper: length of each clock-low phase
   // ----------------------------------------
   logic [7:0] lo_cnt_reg; // cycles the clock line has been pulled
   always_ff @(posedge clk_sys)
   begin
      if (rst || !scl_oe)
         lo_cnt_reg <= 8'h00;
      else
         lo_cnt_reg <= lo_cnt_reg + 8'h01;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_drive_low; 1'b1 |-> !scl_o && !sda_o; endproperty
   a_drive_low: assert property (p_drive_low) else $error("line driven high");
   property p_after_reset; $fell(rst) |-> !scl_oe && !sda_oe && !busy && cmd_ready; endproperty
   a_after_reset: assert property (p_after_reset) else $error("not idle after reset");
   property p_rsp_pulse; rsp_valid |=> !rsp_valid; endproperty
   a_rsp_pulse: assert property (p_rsp_pulse) else $error("response longer than a cycle");
   property p_lines_busy; scl_oe || sda_oe |-> busy; endproperty
   a_lines_busy: assert property (p_lines_busy) else $error("line pulled outside a frame");
   // a start must be followed by the first clock pull two quarters on
   property p_start_clock; $rose(sda_oe) && !scl_oe |-> ##[40:60] $rose(scl_oe); endproperty
   a_start_clock: assert property (p_start_clock) else $error("no clock after start");
   property p_stop_rsp; $fell(sda_oe) && !scl_oe |-> ##[1:60] rsp_valid; endproperty
   a_stop_rsp: assert property (p_stop_rsp) else $error("stop without response");
   property p_low_phase; $fell(scl_oe) |-> lo_cnt_reg >= 8'h14 && lo_cnt_reg <= 8'h3c; endproperty
   a_low_phase: assert property (p_low_phase) else $error("clock low phase out of range");
   property p_cmd_starts; cmd_valid && cmd_ready && !busy && !rsp_valid |-> ##[1:60] busy; endproperty
   a_cmd_starts: assert property (p_cmd_starts) else $error("command did not open a frame");
   property p_rsp_idle; rsp_valid |-> !scl_oe && !sda_oe; endproperty
   a_rsp_idle: assert property (p_rsp_idle) else $error("bus not released at response");
endmodule : aik_ctrl_asserts
bind aik_ctrl aik_ctrl_asserts u_chk (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
   .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .busy(busy), .scl_o(scl_o),
   .scl_oe(scl_oe), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .sda_i(sda_i));

//--- verification/aik_ctrl_tb_top.sv
// self-checking bench: controller against the target model
module aik_ctrl_tb_top
   import aik_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] CFG_RST = 16'h8583;
   localparam logic [15:0] LO_RST = 16'h0000;
   localparam logic [15:0] HI_RST = 16'hffff;
   typedef struct packed {logic [15:0] data; logic nack; logic chk;} aik_exp_type;
   logic clk_sys, rst, cmd_valid, cmd_ready, rsp_valid, busy;
   logic scl_o, scl_oe, sda_o, sda_oe, tgt_oe, saw_full;
   aik_cmd_type cmd;
   aik_rsp_type rsp;
   aik_exp_type ex;
   aik_exp_type exp_q[$]; // notes of expected responses
   logic [1:0] strap; // target select pin
   logic [15:0] ref_reg[4]; // expected register contents
   logic [1:0] ref_ptr;
   int fail_count, check_count;
   wire logic scl_line = !scl_oe; // pull-up wins when released
   wire logic sda_line = !(sda_oe || tgt_oe);
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = !clk_sys;
   end
   aik_ctrl uut (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
      .rsp_valid(rsp_valid), .rsp(rsp), .busy(busy), .scl_o(scl_o), .scl_oe(scl_oe), .scl_i(scl_line),
      .sda_o(sda_o), .sda_oe(sda_oe), .sda_i(sda_line));
   aik_tgt_model #(.CFG_RST(CFG_RST), .LO_RST(LO_RST), .HI_RST(HI_RST)) u_tgt (.scl(scl_line),
      .sda(sda_line), .strap(strap), .sda_oe(tgt_oe));
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   // offer one command and note its answer; valid stays up for a following push
   task automatic push(input aik_op_type op, input logic [1:0] sel, input logic [1:0] p, input logic [15:0] d);
      aik_exp_type e;
      e = '{16'h0000, op != AIK_OP_GRESET && sel != strap, 1'b0};
      if (op == AIK_OP_READ)
         e = '{ref_reg[ref_ptr], sel != strap, sel == strap};
      else if (op == AIK_OP_GRESET)
      begin
         ref_reg = '{16'h0000, CFG_RST, LO_RST, HI_RST};
         ref_ptr = 2'h0;
      end
      else if (sel == strap)
      begin
         ref_ptr = p;
         if (op != AIK_OP_PTR && p != 2'h0)
            ref_reg[p] = d;
      end
      exp_q.push_back(e);
      cmd = '{op, sel, p, d};
      cmd_valid = 1'b1;
      @(negedge clk_sys);
      while (cmd_ready !== 1'b1)
      begin
         saw_full = 1'b1;
         @(negedge clk_sys);
      end
      @(posedge clk_sys);
      #1;
   endtask : push
   // drop valid and wait for every queued frame to finish
   task automatic settle();
      int n;
      cmd_valid = 1'b0;
      n = 0;
      while ((exp_q.size() != 0 || busy !== 1'b0) && n < 30000)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n >= 30000)
      begin
         fail_count++;
         report_and_stop();
      end
      check({scl_line, sda_line}, 2'h3);
   endtask : settle
   // watch responses and compare with the oldest note
   always @(negedge clk_sys)
   begin
      if (rsp_valid === 1'b1 && exp_q.size() == 0)
         check(32'h1, 32'h0);
      else if (rsp_valid === 1'b1)
      begin
         ex = exp_q.pop_front();
         check(rsp.nack, ex.nack);
         if (ex.chk)
            check(rsp.data, ex.data);
      end
   end
   // watchdog: the run needs about 96000 of these 120000 cycles
   initial
   begin
      #(120000 * 100);
      fail_count++;
      report_and_stop();
   end
   initial
   begin
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd = '0;
      strap = 2'h0;
      saw_full = 1'b0;
      fail_count = 0;
      check_count = 0;
      ref_reg = '{16'h0000, CFG_RST, LO_RST, HI_RST};
      ref_ptr = 2'h0;
      void'($urandom(32'h56b5));
      repeat (8) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      // every select strap: write, then read back
      for (int s = 0; s < 4; s++)
      begin
         strap = s[1:0];
         push(AIK_OP_WRITE, strap, 2'h3, 16'($urandom));
         push(AIK_OP_READ, strap, 2'h0, 16'h0000);
         settle();
      end
      // pointer kept across frames; result register ignores writes
      push(AIK_OP_PTR, strap, 2'h1, 16'h0000);
      push(AIK_OP_READ, strap, 2'h0, 16'h0000);
      push(AIK_OP_READ, strap, 2'h0, 16'h0000);
      push(AIK_OP_WRITE, strap, 2'h2, 16'($urandom));
      push(AIK_OP_WRITE, strap, 2'h0, 16'($urandom));
      push(AIK_OP_READ, strap, 2'h0, 16'h0000);
      settle();
      // general-call reset brings back defaults and pointer
      push(AIK_OP_WRITE, strap, 2'h1, 16'($urandom));
      push(AIK_OP_GRESET, strap, 2'h0, 16'h0000);
      push(AIK_OP_READ, strap, 2'h0, 16'h0000);
      push(AIK_OP_PTR, strap, 2'h1, 16'h0000);
      push(AIK_OP_READ, strap, 2'h0, 16'h0000);
      // high-speed code ahead of a write
      push(AIK_OP_HS, strap, 2'h3, 16'($urandom));
      push(AIK_OP_READ, strap, 2'h0, 16'h0000);
      // wrong address is refused and changes nothing
      push(AIK_OP_WRITE, strap ^ 2'h1, 2'h2, 16'($urandom));
      push(AIK_OP_READ, strap ^ 2'h1, 2'h0, 16'h0000);
      push(AIK_OP_READ, strap, 2'h0, 16'h0000);
      settle();
      // flood the queue until it refuses; the previous settle left it empty
      saw_full = 1'b0;
      repeat (10) push(AIK_OP_PTR, strap, 2'h1, 16'h0000);
      settle();
      check(saw_full, 1'b1);
      report_and_stop();
   end
endmodule : aik_ctrl_tb_top

//--- verification/aik_tgt_model.sv
// behavioural converter target on the open-drain two-wire bus
module aik_tgt_model #(
   parameter logic [15:0] CFG_RST = 16'h8583,
   parameter logic [15:0] LO_RST = 16'h0000, // plain default
   parameter logic [15:0] HI_RST = 16'hffff  // plain default
)
(
   input wire logic scl, // never driven here
   input wire logic sda,
   input wire logic [1:0] strap,
   output logic sda_oe // only pulls low
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] regs[4]; // register file
   logic [1:0] ptr_reg; // stored pointer
   logic [7:0] sh;
   logic [7:0] tx;
   logic [7:0] hi;
   int bitn;
   int byten;
   logic act;
   logic rd;
   logic gc;
   logic hs;
   logic moved; // some line changed since the last idle look
   localparam int IDLE_NS = 25000000; // idle limit of the target
   initial
   begin
      regs = '{16'h0000, CFG_RST, LO_RST, HI_RST};
      ptr_reg = 2'h0;
      sda_oe = 1'b0;
      act = 1'b0;
      moved = 1'b0;
   end
   // any line activity keeps a frame alive
   always @(scl or sda)
   begin
      moved = 1'b1;
   end
   // a frame left hanging on a quiet bus is dropped; the controller never idles that long
   initial
   begin
      forever
      begin
         #(IDLE_NS);
         if (act && !moved)
            act = 1'b0;
         moved = 1'b0;
      end
   end
   // start or repeated start opens an address phase
   always @(negedge sda)
   begin
      if (scl)
      begin
         act = 1'b1;
         rd = 1'b0;
         gc = 1'b0;
         bitn = 0;
         byten = 0;
      end
   end
   // stop ends the frame and high-speed filtering
   always @(posedge sda)
   begin
      if (scl)
      begin
         act = 1'b0;
         hs = 1'b0;
      end
   end
   // bits are taken while the clock is high, at any rate
   always @(posedge scl)
   begin
      if (act && bitn < 8)
         sh = {sh[6:0], sda};
      else if (act && rd && byten > 0 && sda)
         act = 1'b0;
      bitn = bitn + 1;
   end
   // act on a whole received byte
   task automatic take_byte();
      if (byten == 0 && sh[7:1] == {5'b10010, strap})
      begin
         rd = sh[0];
         sda_oe <= 1'b1;
      end
      else if (byten == 0 && sh == 8'h00)
      begin
         gc = 1'b1;
         sda_oe <= 1'b1;
      end
      else if (byten == 0 && sh[7:3] == 5'b00001)
      begin
         hs = 1'b1;
         byten = -1;
      end
      else if (byten == 0)
         act = 1'b0;
      else
      begin
         if (gc && sh == 8'h06)
         begin
            regs = '{16'h0000, CFG_RST, LO_RST, HI_RST};
            ptr_reg = 2'h0;
         end
         else if (byten == 1 && !gc)
            ptr_reg = sh[1:0];
         else if (byten == 2)
            hi = sh;
         else if (byten == 3 && ptr_reg != 2'h0)
            regs[ptr_reg] = {hi, sh};
         sda_oe <= 1'b1;
      end
   endtask : take_byte
   // the data line changes only while the clock is low
   always @(negedge scl)
   begin
      sda_oe <= 1'b0;
      if (act && bitn == 8 && !(rd && byten > 0))
         take_byte();
      else if (act && bitn == 9)
      begin
         bitn = 0;
         byten = byten + 1;
         tx = (byten == 1) ? regs[ptr_reg][15:8] : regs[ptr_reg][7:0];
         if (rd)
            sda_oe <= !tx[7];
      end
      else if (act && rd && bitn < 8)
         sda_oe <= !tx[7 - bitn];
   end
endmodule : aik_tgt_model
